// ### reset_init_map.svh
/*
  Register offsets, field positions, reset values and vectors of the
  reset and wake-up initialiser. Assumes byte addresses on a 32-bit
  AXI4-Lite bus, one register per aligned word.
*/
`ifndef RESET_INIT_MAP_SVH
`define RESET_INIT_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_PC 8'h00
`define OFS_TOS_U 8'h04
`define OFS_TOS_H 8'h08
`define OFS_TOS_L 8'h0c
`define OFS_STK_PTR 8'h10
`define OFS_INTCON0 8'h14
`define OFS_INTCON1 8'h18
`define OFS_INTCON2 8'h1c
`define OFS_PIR1 8'h20
`define OFS_PIR2 8'h24
`define OFS_PIR3 8'h28
`define OFS_PA_IN 8'h2c
`define OFS_PA_LAT 8'h30
`define OFS_PA_DIR 8'h34
`define OFS_CAUSE 8'h38
`define OFS_IRQ_STS 8'h3c
`define OFS_IRQ_MASK 8'h40
`define OFS_CONFIG 8'h44
`define OFS_STK_PEEK 8'h48

// ****************************************
// field positions
// ****************************************
`define BIT_HIGH_EN 7
`define BIT_LOW_EN 6
`define BIT_STK_FULL 7
`define BIT_STK_UNF 6
`define BIT_OSC_FREE 0
`define BIT_CAUSE_OSC 7

// ****************************************
// reset values and implemented-bit masks
// ****************************************
`define RST_INTCON0 8'h00
`define RST_INTCON1 8'hff
`define RST_INTCON2 8'hc0
`define RST_PA_DIR 8'hff
`define RST_ZERO8 8'h00
`define IMPL_TOS_U 8'h1f
`define IMPL_PIR1 8'hff
`define IMPL_PIR2 8'h3f
`define IMPL_PIR3 8'h07
`define IMPL_PA_LOW 8'h3f

// ****************************************
// program counter targets and bus answers
// ****************************************
`define VEC_HIGH 21'h00_0008
`define VEC_LOW 21'h00_0018
`define PC_STEP 21'h00_0002
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### reset_init_pkg.sv
/*
  Types shared by the reset and wake-up initialiser.
  Assumes nothing of its surroundings.
*/
package reset_init_pkg;

  // which set of initial values applies in a cycle
  typedef enum logic [1:0] {
    CLASS_NONE,
    CLASS_POWER,
    CLASS_WARM,
    CLASS_WAKE
  } reset_class_type;

endpackage

// ### stack_mem.sv
/*
  Hardware return stack storage: one write port, one read port whose
  data come out of a register. Assumes one clock, no reset on the cells.
*/
`timescale 1ns/1ps

module stack_mem #(
  parameter int DEPTH = 31,
  parameter int AW = 5,
  parameter int DW = 21
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  typedef struct packed {
    logic [DEPTH:0][DW-1:0] cells;
    logic [DW-1:0] rd;
  } mem_state_type;

  mem_state_type m_q;
  mem_state_type m_d;

  always_comb
  begin
    m_d = m_q;
    if (we)
    begin
      m_d.cells[waddr] = wdata;
    end
    m_d.rd = m_q.cells[raddr];
  end

  always_ff @(posedge aclk)
  begin
    m_q <= m_d;
  end

  assign rdata = m_q.rd;

endmodule // stack_mem

// ### reset_init.sv
/*
  Reset and wake-up initialiser of the core registers, with an AXI4-Lite
  register port, event interrupt and port A bits 7:6 gating.
  Assumes reset and wake events are one-cycle pulses synchronous to aclk.
*/
// Functional notes
// - interrupt wake with global enable loads vector
// - enabled interrupt wake pushes pc, bumps stack pointer, or at STACK_DEPTH sets full and holds it
// - port A bits 7:6 live only when freed
// - wake keeps causing flags, others unchanged
// - unimplemented bits always read zero
// - warm resets share one initial value set
// - condition bits follow the actual event
`timescale 1ns/1ps
`include "reset_init_map.svh"

module reset_init #(
  parameter int STACK_DEPTH = 31
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic evt_por_bor,
  input wire logic evt_master_clear,
  input wire logic evt_wdt_reset,
  input wire logic evt_reset_instr,
  input wire logic evt_stack_reset,
  input wire logic evt_wake_wdt,
  input wire logic evt_wake_int,
  input wire logic [7:0] wake_intcon_flags,
  input wire logic [23:0] wake_pir_flags,
  input wire logic osc_stable,
  input wire logic [7:0] port_a_pins,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import reset_init_pkg::*;

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rd_pend;
    logic [7:0] ar_addr;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [20:0] pc;
    logic [20:0] tos;
    logic stk_full;
    logic stk_unf;
    logic [4:0] stk_ptr;
    logic [2:0][7:0] intcon;
    logic [2:0][7:0] pir;
    logic [7:0] pa_lat;
    logic [7:0] pa_dir;
    logic osc_free;
    logic [7:0] cause;
    logic [5:0] irq_sts;
    logic [5:0] irq_mask;
  } state_type;

  localparam logic [23:0] PIR_IMPL = {`IMPL_PIR3, `IMPL_PIR2, `IMPL_PIR1};

  state_type s_q;
  state_type s_d;
  reset_class_type cls;
  logic warm_evt;
  logic wake_evt;
  logic gie_any;
  logic push;
  logic [7:0] pa_en;
  logic [20:0] peek;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic wr_hit;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [5:0] irq_set;

  // ****************************************
  // event classification
  // ****************************************
  assign warm_evt = evt_master_clear | evt_wdt_reset | evt_reset_instr | evt_stack_reset;
  assign wake_evt = evt_wake_wdt | evt_wake_int;
  assign gie_any = s_q.intcon[0][`BIT_HIGH_EN] | s_q.intcon[0][`BIT_LOW_EN];
  assign cls = evt_por_bor ? CLASS_POWER : (warm_evt ? CLASS_WARM : (wake_evt ? CLASS_WAKE : CLASS_NONE));

  assign push = (cls == CLASS_WAKE) && evt_wake_int && gie_any;
  assign irq_set = {wake_evt, evt_stack_reset, evt_reset_instr, evt_wdt_reset, evt_master_clear, evt_por_bor};

  stack_mem #(.DEPTH(STACK_DEPTH), .AW(5), .DW(21)) u_stack (
    .aclk(aclk),
    .we(push && !s_q.stk_full),
    .waddr(s_q.stk_ptr + 5'd1),
    .wdata(s_q.pc),
    .raddr(s_q.stk_ptr),
    .rdata(peek)
  );

  // ****************************************
  // register read decode
  // ****************************************
  assign pa_en = s_q.osc_free ? 8'hff : `IMPL_PA_LOW;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_q.ar_addr)
      `OFS_PC: rd_mux = {11'h000, s_q.pc};
      `OFS_TOS_U: rd_mux = {24'h00_0000, 3'h0, s_q.tos[20:16]};
      `OFS_TOS_H: rd_mux = {24'h00_0000, s_q.tos[15:8]};
      `OFS_TOS_L: rd_mux = {24'h00_0000, s_q.tos[7:0]};
      `OFS_STK_PTR: rd_mux = {24'h00_0000, s_q.stk_full, s_q.stk_unf, 1'b0, s_q.stk_ptr};
      `OFS_INTCON0: rd_mux = {24'h00_0000, s_q.intcon[0]};
      `OFS_INTCON1: rd_mux = {24'h00_0000, s_q.intcon[1]};
      `OFS_INTCON2: rd_mux = {24'h00_0000, s_q.intcon[2]};
      `OFS_PIR1: rd_mux = {24'h00_0000, s_q.pir[0] & `IMPL_PIR1};
      `OFS_PIR2: rd_mux = {24'h00_0000, s_q.pir[1] & `IMPL_PIR2};
      `OFS_PIR3: rd_mux = {24'h00_0000, s_q.pir[2] & `IMPL_PIR3};
      `OFS_PA_IN: rd_mux = {24'h00_0000, port_a_pins & pa_en};
      `OFS_PA_LAT: rd_mux = {24'h00_0000, s_q.pa_lat & pa_en};
      `OFS_PA_DIR: rd_mux = {24'h00_0000, s_q.pa_dir & pa_en};
      `OFS_CAUSE: rd_mux = {24'h00_0000, s_q.cause};
      `OFS_IRQ_STS: rd_mux = {26'h000_0000, s_q.irq_sts};
      `OFS_IRQ_MASK: rd_mux = {26'h000_0000, s_q.irq_mask};
      `OFS_CONFIG: rd_mux = {31'h0000_0000, s_q.osc_free};
      `OFS_STK_PEEK: rd_mux = {11'h000, peek};
      default: rd_hit = 1'b0;
    endcase
  end

  // ****************************************
  // write data and decode
  // ****************************************
  assign wmask = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}}, {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
  assign wval = s_q.w_data;
  // map is dense: every aligned word up to the last register
  assign wr_hit = (s_q.aw_addr[1:0] == 2'b00) && (s_q.aw_addr <= `OFS_STK_PEEK);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    if (s_axi_awvalid && !s_q.aw_held)
    begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_held)
    begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      if (s_q.w_strb[0])
      begin
        unique case (s_q.aw_addr)
          `OFS_TOS_U: s_d.tos[20:16] = wval[4:0];
          `OFS_TOS_H: s_d.tos[15:8] = wval[7:0];
          `OFS_TOS_L: s_d.tos[7:0] = wval[7:0];
          `OFS_STK_PTR: {s_d.stk_full, s_d.stk_unf, s_d.stk_ptr} = {wval[7:6], wval[4:0]};
          `OFS_INTCON0: s_d.intcon[0] = wval[7:0];
          `OFS_INTCON1: s_d.intcon[1] = wval[7:0];
          `OFS_INTCON2: s_d.intcon[2] = wval[7:0];
          `OFS_PIR1: s_d.pir[0] = wval[7:0] & `IMPL_PIR1;
          `OFS_PIR2: s_d.pir[1] = wval[7:0] & `IMPL_PIR2;
          `OFS_PIR3: s_d.pir[2] = wval[7:0] & `IMPL_PIR3;
          `OFS_PA_LAT: s_d.pa_lat = wval[7:0];
          `OFS_PA_DIR: s_d.pa_dir = wval[7:0];
          `OFS_IRQ_STS: s_d.irq_sts = s_q.irq_sts & ~wval[5:0];
          `OFS_IRQ_MASK: s_d.irq_mask = wval[5:0];
          `OFS_CONFIG: s_d.osc_free = wval[`BIT_OSC_FREE];
          default: s_d.osc_free = s_q.osc_free;
        endcase
      end
      if (s_q.aw_addr == `OFS_PC)
        s_d.pc = (s_q.pc & ~wmask[20:0]) | (wval[20:0] & wmask[20:0]);
    end
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    if (s_axi_arvalid && !s_q.rd_pend && !s_q.rvalid)
    begin
      s_d.rd_pend = 1'b1;
      s_d.ar_addr = s_axi_araddr;
    end
    if (s_q.rd_pend)
    begin
      s_d.rd_pend = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_mux;
      s_d.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    // reset and wake events override software writes
    unique case (cls)
      CLASS_POWER:
      begin
        s_d.pc = 21'h00_0000;
        s_d.tos = 21'h00_0000;
        s_d.stk_ptr = 5'h00;
        s_d.intcon[0][7:1] = 7'(`RST_INTCON0 >> 1);
        s_d.intcon[1] = `RST_INTCON1;
        s_d.intcon[2] = `RST_INTCON2;
        s_d.pir = {3{`RST_ZERO8}};
        s_d.pa_dir = `RST_PA_DIR;
        s_d.cause = {osc_stable, 7'h01};
      end
      CLASS_WARM:
      begin
        s_d.pc = 21'h00_0000;
        s_d.tos = 21'h00_0000;
        s_d.stk_ptr = 5'h00;
        s_d.stk_full = 1'b0;
        s_d.stk_unf = 1'b0;
        s_d.intcon[0][7:1] = 7'(`RST_INTCON0 >> 1);
        s_d.intcon[1] = `RST_INTCON1;
        s_d.intcon[2] = `RST_INTCON2;
        s_d.pir = {3{`RST_ZERO8}};
        s_d.pa_dir = `RST_PA_DIR;
        s_d.cause = {osc_stable, 2'b00, evt_stack_reset, evt_reset_instr, evt_wdt_reset, evt_master_clear, 1'b0};
      end
      CLASS_WAKE:
      begin
        s_d.cause = {osc_stable, evt_wake_int, evt_wake_wdt, 5'h00};
        if (push)
        begin
          s_d.pc = s_q.intcon[0][`BIT_HIGH_EN] ? `VEC_HIGH : `VEC_LOW;
          s_d.tos = s_q.pc;
          if (s_q.stk_ptr == 5'(STACK_DEPTH))
            s_d.stk_full = 1'b1;
          else
            s_d.stk_ptr = s_q.stk_ptr + 5'd1;
        end
        else
          s_d.pc = s_q.pc + `PC_STEP;
        if (evt_wake_int)
        begin
          s_d.intcon[0] = s_q.intcon[0] | wake_intcon_flags;
          s_d.pir = s_q.pir | (wake_pir_flags & PIR_IMPL);
        end
      end
      CLASS_NONE: s_d.cause = s_q.cause;
    endcase
    s_d.irq_sts = s_d.irq_sts | irq_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.intcon[1] <= `RST_INTCON1;
      s_q.intcon[2] <= `RST_INTCON2;
      s_q.pa_dir <= `RST_PA_DIR;
    end
    else
      s_q <= s_d;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready = !s_q.aw_held;
  assign s_axi_wready = !s_q.w_held;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rd_pend && !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign port_a_out = s_q.pa_lat & pa_en;
  assign port_a_oe = ~s_q.pa_dir & pa_en;
  assign irq = |(s_q.irq_sts & s_q.irq_mask);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_VECTOR_HIGH: assert property (push && s_q.intcon[0][`BIT_HIGH_EN] |=> s_q.pc == 21'h00_0008)
    else $error("high vector not loaded");
  AST_VECTOR_LOW: assert property (push && !s_q.intcon[0][`BIT_HIGH_EN] |=> s_q.pc == 21'h00_0018)
    else $error("low vector not loaded");
  AST_PUSH_PTR: assert property (push && s_q.stk_ptr < 5'(STACK_DEPTH) |=> s_q.stk_ptr == $past(s_q.stk_ptr) + 5'd1)
    else $error("stack pointer not advanced");
  AST_TOS_COPY: assert property (push |=> s_q.tos == $past(s_q.pc))
    else $error("top of stack not loaded from pc");
  AST_PA_GATED: assert property (!s_q.osc_free |-> port_a_oe[7:6] == 2'b00 && port_a_out[7:6] == 2'b00)
    else $error("port a high bits active while claimed");
  AST_WAKE_FLAGS: assert property (cls == CLASS_WAKE && evt_wake_int
    |=> (s_q.pir & $past(wake_pir_flags) & PIR_IMPL) == ($past(wake_pir_flags) & PIR_IMPL))
    else $error("wake flag lost");
  AST_WAKE_KEEP: assert property (cls == CLASS_WAKE |=> s_q.intcon[2] == $past(s_q.intcon[2]))
    else $error("wake changed unrelated bits");
  AST_RD_UPPER_ZERO: assert property (s_q.rd_pend && s_q.ar_addr == `OFS_STK_PTR
    |=> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[5])
    else $error("unimplemented bit read non-zero");
  AST_WARM_SET: assert property (cls == CLASS_WARM
    |=> s_q.intcon[1] == 8'hff && s_q.intcon[2] == 8'hc0 && s_q.pc == 21'h0 && s_q.stk_ptr == 5'h0)
    else $error("warm reset values wrong");
  AST_CAUSE_WDT: assert property (cls == CLASS_WARM && evt_wdt_reset |=> s_q.cause[2] && !s_q.cause[0])
    else $error("reset cause not recorded");
  AST_POWER_SET: assert property (cls == CLASS_POWER |=> s_q.pa_dir == 8'hff && s_q.cause[0])
    else $error("power-on values wrong");

endmodule // reset_init

// ### test_reset_init.sv
/*
  Self-checking bench of reset_init: AXI4-Lite register tasks, event pulses, compares.
  Assumes reset_init_map.svh and reset_init_pkg are compiled ahead of this file.
*/
`timescale 1ns/1ps
`include "reset_init_map.svh"

module test_reset_init;
  import reset_init_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [6:0] evt = '0;
  logic [7:0] icf = '0;
  logic [23:0] pirf = '0;
  logic osc = 1'b0;
  logic [7:0] pins = '0;
  logic [7:0] pa_out;
  logic [7:0] pa_oe;
  logic irq;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready;
  logic wready;
  logic arready;
  logic bvalid;
  logic rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic [1:0] wr_resp;
  int n_mismatch = 0;
  int check_count = 0;
  logic [7:0] impl_ofs [4] = '{`OFS_TOS_U, `OFS_PIR1, `OFS_PIR2, `OFS_PIR3};
  logic [7:0] impl_exp [4] = '{`IMPL_TOS_U, `IMPL_PIR1, `IMPL_PIR2, `IMPL_PIR3};

  always #2 aclk = ~aclk;

  reset_init dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .evt_por_bor(evt[0]),
    .evt_master_clear(evt[1]),
    .evt_wdt_reset(evt[2]),
    .evt_reset_instr(evt[3]),
    .evt_stack_reset(evt[4]),
    .evt_wake_wdt(evt[5]),
    .evt_wake_int(evt[6]),
    .wake_intcon_flags(icf),
    .wake_pir_flags(pirf),
    .osc_stable(osc),
    .port_a_pins(pins),
    .port_a_out(pa_out),
    .port_a_oe(pa_oe),
    .irq(irq),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!(bvalid && bready));
    wr_resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!(rvalid && rready));
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    check(rd_data, exp);
  endtask

  // one-cycle event pulse with wake flags beside it
  task automatic pulse(input int i, input logic [7:0] fi, input logic [23:0] fp);
    evt[i] <= 1'b1;
    icf <= fi;
    pirf <= fp;
    @(posedge aclk);
    evt <= '0;
    icf <= '0;
    pirf <= '0;
    @(posedge aclk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    #(4 * 8000);
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(32'(pa_oe), 32'h0);
    rd_chk(`OFS_INTCON0, 32'h00);
    check(32'(rd_resp), 32'(`RESP_OKAY));
    rd_chk(`OFS_INTCON1, 32'hff);
    rd_chk(`OFS_INTCON2, 32'hc0);
    rd_chk(`OFS_PA_DIR, 32'h3f);
    for (int k = 0; k < 4; k++)
    begin
      axi_write(impl_ofs[k], 32'hffff_ffff);
      check(32'(wr_resp), 32'(`RESP_OKAY));
      rd_chk(impl_ofs[k], 32'(impl_exp[k]));
    end
    rd_chk(8'hfc, 32'h0);
    check(32'(rd_resp), 32'(`RESP_SLVERR));
    axi_write(8'hfc, 32'h1);
    check(32'(wr_resp), 32'(`RESP_SLVERR));
    // port A bits 7:6 gated, then freed
    pins <= 8'hff;
    axi_write(`OFS_CONFIG, 32'h0);
    axi_write(`OFS_PA_LAT, 32'hff);
    axi_write(`OFS_PA_DIR, 32'hc0);
    rd_chk(`OFS_PA_LAT, 32'h3f);
    rd_chk(`OFS_PA_DIR, 32'h00);
    rd_chk(`OFS_PA_IN, 32'h3f);
    check(32'(pa_out), 32'h3f);
    check(32'(pa_oe), 32'h3f);
    axi_write(`OFS_CONFIG, 32'h1);
    axi_write(`OFS_PA_LAT, 32'hff);
    axi_write(`OFS_PA_DIR, 32'h40);
    pins <= 8'h96;
    rd_chk(`OFS_PA_LAT, 32'hff);
    rd_chk(`OFS_PA_DIR, 32'h40);
    rd_chk(`OFS_PA_IN, 32'h96);
    check(32'(pa_out), 32'hff);
    check(32'(pa_oe), 32'hbf);
    // interrupt wake, high priority enable
    axi_write(`OFS_PIR1, 32'h01);
    axi_write(`OFS_PIR2, 32'h00);
    axi_write(`OFS_INTCON1, 32'h12);
    axi_write(`OFS_PC, 32'h0001_2344);
    axi_write(`OFS_INTCON0, 32'h80);
    pulse(6, 8'h04, 24'h00_c1_10);
    rd_chk(`OFS_PC, {11'h0, `VEC_HIGH});
    rd_chk(`OFS_TOS_U, 32'h01);
    rd_chk(`OFS_TOS_H, 32'h23);
    rd_chk(`OFS_TOS_L, 32'h44);
    rd_chk(`OFS_STK_PTR, 32'h01);
    rd_chk(`OFS_INTCON0, 32'h84);
    rd_chk(`OFS_PIR1, 32'h11);
    rd_chk(`OFS_PIR2, 32'h01);
    rd_chk(`OFS_INTCON1, 32'h12);
    // low priority enable, then no enable
    axi_write(`OFS_INTCON0, 32'h40);
    axi_write(`OFS_PC, 32'h100);
    pulse(6, 8'h00, 24'h0);
    rd_chk(`OFS_PC, {11'h0, `VEC_LOW});
    rd_chk(`OFS_TOS_H, 32'h01);
    rd_chk(`OFS_STK_PTR, 32'h02);
    rd_chk(`OFS_STK_PEEK, 32'h100);
    axi_write(`OFS_INTCON0, 32'h00);
    axi_write(`OFS_PC, 32'h200);
    pulse(6, 8'h00, 24'h0);
    rd_chk(`OFS_PC, 32'h202);
    pulse(5, 8'h00, 24'h0);
    rd_chk(`OFS_PC, 32'h204);
    rd_chk(`OFS_STK_PTR, 32'h02);
    // push at the last entry marks the stack full, pointer stays
    axi_write(`OFS_STK_PTR, 32'h1f);
    axi_write(`OFS_INTCON0, 32'h80);
    pulse(6, 8'h00, 24'h0);
    rd_chk(`OFS_STK_PTR, 32'h9f);
    rd_chk(`OFS_PC, {11'h0, `VEC_HIGH});
    // every warm reset source
    for (int i = 1; i < 5; i++)
    begin
      osc <= i[0];
      axi_write(`OFS_INTCON1, 32'h0);
      axi_write(`OFS_PA_DIR, 32'h0);
      axi_write(`OFS_PC, 32'h100);
      pulse(i, 8'h00, 24'h0);
      rd_chk(`OFS_INTCON1, 32'hff);
      rd_chk(`OFS_PA_DIR, 32'hff);
      rd_chk(`OFS_PC, 32'h0);
      rd_chk(`OFS_STK_PTR, 32'h0);
      axi_read(`OFS_CAUSE);
      check({31'h0, rd_data[i]}, 32'h1);
      check({31'h0, rd_data[7]}, {31'h0, osc});
    end
    // sticky status, mask, one-to-clear
    rd_chk(`OFS_IRQ_STS, 32'h3e);
    check({31'h0, irq}, 32'h0);
    axi_write(`OFS_IRQ_MASK, 32'h02);
    check({31'h0, irq}, 32'h1);
    axi_write(`OFS_IRQ_STS, 32'h02);
    rd_chk(`OFS_IRQ_STS, 32'h3c);
    check({31'h0, irq}, 32'h0);
    // power reset
    axi_write(`OFS_INTCON1, 32'h0);
    axi_write(`OFS_PC, 32'h100);
    pulse(0, 8'h00, 24'h0);
    rd_chk(`OFS_INTCON1, 32'hff);
    rd_chk(`OFS_PC, 32'h0);
    axi_read(`OFS_CAUSE);
    check({31'h0, rd_data[0]}, 32'h1);
    tally_and_finish();
  end

endmodule // test_reset_init
